// [common/twwrc_pkg.sv]
// shared constants and carriers for the two-wire write-only control port
// assumes one system clock domain; serial pins are asynchronous to it
package twwrc_pkg;
   // ***************
   // frame layout
   // ***************
   localparam int ADDR_BITS = 3;
   localparam int DATA_BITS = 8;
   localparam int FRAME_BITS = ADDR_BITS + DATA_BITS;
   localparam int NUM_SELECTS = 8;
   localparam int NUM_REGS = 4;
   // ***************
   // register addresses
   // ***************
   localparam logic [2:0] ADDR_CONTROL_CONFIG = 3'h0;
   localparam logic [2:0] ADDR_MODULATION_LEVEL = 3'h1;
   localparam logic [2:0] ADDR_BIAS_LEVEL = 3'h2;
   localparam logic [2:0] ADDR_EQUALIZER_STRENGTH = 3'h3;
   // ***************
   // control_config fields
   // ***************
   localparam int BIT_CHIP_ENABLE = 7;
   localparam int BIT_PHOTODIODE_POLARITY = 6;
   localparam int BIT_PHOTODIODE_RANGE = 5;
   localparam int BIT_OPEN_LOOP = 4;
   localparam int BIT_FAULT_DETECT_ENABLE = 3;
   localparam int BIT_MODULATION_RANGE = 2;
   localparam int BIT_EQUALIZER_BYPASS = 1;
   // ***************
   // reset values
   // ***************
   localparam logic [7:0] RESET_CONTROL_CONFIG = 8'h00;
   localparam logic [7:0] RESET_MODULATION_LEVEL = 8'h00;
   localparam logic [7:0] RESET_BIAS_LEVEL = 8'h00;
   localparam logic [7:0] RESET_EQUALIZER_STRENGTH = 8'h00;
   // ***************
   // timing figures, ns, and cycles at the 40 ns clock
   // ***************
   localparam int CLK_PERIOD_NS = 40;
   localparam int SYNC_STAGES = 2;

   typedef struct packed {
      logic chip_enable_bit;
      logic photodiode_polarity_bit;
      logic photodiode_range_bit;
      logic open_loop_bit;
      logic fault_detect_enable_bit;
      logic modulation_range_bit;
      logic equalizer_bypass_bit;
      logic unused_bit;
   } twwrc_control_t;

   typedef struct packed {
      logic [ADDR_BITS-1:0] addr;
      logic [DATA_BITS-1:0] data;
   } twwrc_frame_t;

   typedef struct packed {
      logic modulation_enable;
      logic modulation_range_bit;
      logic [DATA_BITS-1:0] modulation_level_value;
      logic equalizer_enable;
      logic [DATA_BITS-1:0] equalizer_strength_field;
   } twwrc_analog_ctl_t;
endpackage

// [hdl/twwrc_sync.sv]
// two-flop synchroniser for a bank of asynchronous pin levels
// assumes inputs are levels from outside the clk domain
`timescale 1ns/100ps
module twwrc_sync #(
   parameter int WIDTH = 3
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta;

   // serial lines idle high, so both stages reset high for every bit, the kill pin's too
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta <= {WIDTH{1'b1}};
         sync_out <= {WIDTH{1'b1}};
      end else begin
         meta <= async_in;
         sync_out <= meta;
      end
   end
endmodule

// [hdl/twwrc_top.sv]
// two-wire write-only control port and the four control registers behind it
// assumes serial_clk, serial_data, output_kill_pin and fault_in are asynchronous
`timescale 1ns/100ps
module twwrc_top
   import twwrc_pkg::*;
#(
   parameter int FRAME_LEN = FRAME_BITS
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic serial_clk,
   input wire logic serial_data,
   input wire logic output_kill_pin,
   input wire logic fault_in,
   output twwrc_control_t control_config,
   output logic [DATA_BITS-1:0] modulation_level,
   output logic [DATA_BITS-1:0] bias_level,
   output logic [DATA_BITS-1:0] equalizer_strength,
   output twwrc_analog_ctl_t analog_ctl,
   output logic fault_latched,
   output logic [NUM_SELECTS-1:0] write_select,
   output logic write_strobe
);
   // ***************
   // pin synchronisation
   // ***************
   logic [2:0] pins_sync;
   logic scl;
   logic sda;
   logic kill;
   logic scl_d;
   logic sda_d;
   logic fault_s1;
   logic fault_s2;

   twwrc_sync #(.WIDTH(3)) u_sync (
      .clk(clk),
      .arst_n(arst_n),
      .async_in({serial_clk, serial_data, output_kill_pin}),
      .sync_out(pins_sync)
   );

   assign scl = pins_sync[2];
   assign sda = pins_sync[1];
   assign kill = pins_sync[0];

   // fault input idles low, so its own pair resets low
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         fault_s1 <= 1'b0;
         fault_s2 <= 1'b0;
      end else begin
         fault_s1 <= fault_in;
         fault_s2 <= fault_s1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= scl;
         sda_d <= sda;
      end
   end

   // ***************
   // condition detection
   // ***************
   logic start_cond;
   logic stop_cond;
   logic scl_rise;

   // start, stop and clock-rise detect
   // edges seen after sync, so clock and data must both be stable a few cycles
   assign start_cond = scl && scl_d && sda_d && !sda;
   assign stop_cond = scl && scl_d && !sda_d && sda;
   assign scl_rise = scl && !scl_d;

   // ***************
   // frame receiver
   // ***************
   typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_WAIT_STOP} twwrc_state_t;
   twwrc_state_t state;
   twwrc_frame_t shift_reg;
   logic [3:0] bit_count;
   logic commit;

   localparam logic [3:0] LAST_BIT = 4'(FRAME_LEN);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= ST_IDLE;
      end else if (start_cond) begin
         state <= ST_SHIFT;
      end else begin
         case (state)
            ST_IDLE: begin
               state <= ST_IDLE;
            end
            ST_SHIFT: begin
               if (stop_cond) begin
                  state <= ST_IDLE;
               end else if (scl_rise && bit_count == LAST_BIT - 4'h1) begin
                  state <= ST_WAIT_STOP;
               end
            end
            ST_WAIT_STOP: begin
               if (stop_cond) begin
                  state <= ST_IDLE;
               end else if (scl_rise && bit_count != LAST_BIT) begin
                  // the stop's own clock rise is allowed; any later rise voids the frame
                  state <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // shift on clock rise, msb first
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         shift_reg <= '0;
         bit_count <= 4'h0;
      end else if (start_cond) begin
         bit_count <= 4'h0;
      end else if (state == ST_SHIFT && scl_rise) begin
         shift_reg <= {shift_reg[FRAME_BITS-2:0], sda};
         bit_count <= bit_count + 4'h1;
      end else if (state == ST_WAIT_STOP && scl_rise && bit_count == LAST_BIT) begin
         // count the stop's clock rise so a further rise can be told apart
         bit_count <= bit_count + 4'h1;
      end
   end

   // commit on stop after full frame
   assign commit = state == ST_WAIT_STOP && stop_cond;

   function automatic logic [NUM_SELECTS-1:0] decode_addr(input logic [ADDR_BITS-1:0] a);
      decode_addr = NUM_SELECTS'(1) << a;
   endfunction

   logic [NUM_SELECTS-1:0] sel;
   assign sel = decode_addr(shift_reg.addr);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         write_select <= '0;
         write_strobe <= 1'b0;
      end else begin
         write_strobe <= commit;
         write_select <= commit ? sel : '0;
      end
   end

   // ***************
   // register bank
   // ***************
   // only four selects reach storage
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         control_config <= RESET_CONTROL_CONFIG;
      end else if (commit && sel[ADDR_CONTROL_CONFIG]) begin
         control_config <= {shift_reg.data[7:1], 1'b0};
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         modulation_level <= RESET_MODULATION_LEVEL;
      end else if (commit && sel[ADDR_MODULATION_LEVEL]) begin
         modulation_level <= shift_reg.data;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         bias_level <= RESET_BIAS_LEVEL;
      end else if (commit && sel[ADDR_BIAS_LEVEL]) begin
         bias_level <= shift_reg.data;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         equalizer_strength <= RESET_EQUALIZER_STRENGTH;
      end else if (commit && sel[ADDR_EQUALIZER_STRENGTH]) begin
         equalizer_strength <= shift_reg.data;
      end
   end

   // ***************
   // fault latch
   // ***************
   logic ena_d;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ena_d <= 1'b0;
      end else begin
         ena_d <= control_config.chip_enable_bit;
      end
   end

   // detection only when enabled
   // a fault present at the re-enable edge sets again, so set wins
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         fault_latched <= 1'b0;
      end else if (fault_s2 && control_config.fault_detect_enable_bit) begin
         fault_latched <= 1'b1;
      end else if (control_config.chip_enable_bit && !ena_d) begin
         fault_latched <= 1'b0;
      end
   end

   // ***************
   // analog control outputs
   // ***************
   logic next_mod_enable;
   assign next_mod_enable = control_config.chip_enable_bit && !kill
                            && !(fault_latched && control_config.fault_detect_enable_bit);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         analog_ctl <= '0;
      end else begin
         analog_ctl.modulation_enable <= next_mod_enable;
         analog_ctl.modulation_range_bit <= control_config.modulation_range_bit;
         analog_ctl.modulation_level_value <= modulation_level;
         analog_ctl.equalizer_enable <= !control_config.equalizer_bypass_bit;
         analog_ctl.equalizer_strength_field <= equalizer_strength;
      end
   end
endmodule

// [tb/twwrc_mcu_model.sv]
// microcontroller model driving the two serial lines of the control port
// assumes clk is the bench clock; send aligns itself to a rising clk edge
`timescale 1ns/100ps
module twwrc_mcu_model (
   input wire logic clk,
   output logic serial_clk,
   output logic serial_data
);
   initial begin
      serial_clk = 1'b1;
      serial_data = 1'b1;
   end
   task automatic step(input logic c, input logic d, input int n);
      serial_clk <= c;
      serial_data <= d;
      repeat (n) @(posedge clk);
   endtask
   task automatic send(input logic [10:0] f, input bit stop);
      @(posedge clk);
      step(1'b1, 1'b0, 4);
      step(1'b0, 1'b0, 2);
      for (int i = 10; i >= 0; i--) begin
         step(1'b0, f[i], 2);
         step(1'b1, f[i], 4);
         step(1'b0, f[i], 2);
      end
      // without stop, data rises while the clock is still low
      step(1'b0, !stop, 2);
      step(1'b1, !stop, 4);
      step(1'b1, 1'b1, 1);
   endtask
endmodule

// [tb/twwrc_top_chk.sv]
// port-level checker for the two-wire control port
// assumes bind onto twwrc_top; one clk domain
`timescale 1ns/100ps
module twwrc_top_chk
   import twwrc_pkg::*;
#(
   parameter int FRAME_LEN = FRAME_BITS
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic serial_clk,
   input wire logic serial_data,
   input wire logic output_kill_pin,
   input wire logic fault_in,
   input wire twwrc_control_t control_config,
   input wire logic [DATA_BITS-1:0] modulation_level,
   input wire logic [DATA_BITS-1:0] bias_level,
   input wire logic [DATA_BITS-1:0] equalizer_strength,
   input wire twwrc_analog_ctl_t analog_ctl,
   input wire logic fault_latched,
   input wire logic [NUM_SELECTS-1:0] write_select,
   input wire logic write_strobe
);
   logic [31:0] regs;
   assign regs = {control_config, modulation_level, bias_level, equalizer_strength};
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   select_onehot_a: assert property (write_strobe |-> $onehot(write_select))
      else $error("select not one-hot at strobe");
   select_idle_a: assert property (!write_strobe |-> write_select == 8'h00)
      else $error("select active without strobe");
   strobe_pulse_a: assert property (write_strobe |=> !write_strobe)
      else $error("strobe longer than one cycle");
   commit_only_a: assert property ($changed(regs) |-> write_strobe)
      else $error("register changed without strobe");
   reserved_hold_a: assert property (write_strobe && write_select[7:4] != 4'h0 |-> $stable(regs))
      else $error("reserved address changed a register");
   bit0_zero_a: assert property (control_config.unused_bit == 1'b0)
      else $error("unused config bit set");
   eq_route_a: assert property ($past(arst_n) |-> analog_ctl.equalizer_enable ==
      !$past(control_config.equalizer_bypass_bit))
      else $error("equalizer enable wrong");
   level_copy_a: assert property ($past(arst_n) |-> {analog_ctl.modulation_level_value,
      analog_ctl.equalizer_strength_field, analog_ctl.modulation_range_bit} ==
      $past({modulation_level, equalizer_strength, control_config.modulation_range_bit}))
      else $error("analog control copy wrong");
   enable_gate_a: assert property ($past(arst_n) && !$past(control_config.chip_enable_bit)
      |-> !analog_ctl.modulation_enable)
      else $error("modulation on while disabled");
   fault_gate_a: assert property ($past(arst_n) && $past(fault_latched &&
      control_config.fault_detect_enable_bit) |-> !analog_ctl.modulation_enable)
      else $error("modulation on during fault");
   kill_gate_a: assert property (output_kill_pin [*5] |-> !analog_ctl.modulation_enable)
      else $error("modulation on while killed");
   fault_catch_a: assert property ((fault_in && control_config.fault_detect_enable_bit) [*5]
      |-> fault_latched)
      else $error("fault not latched");
endmodule
bind twwrc_top twwrc_top_chk #(.FRAME_LEN(FRAME_LEN)) chk (.clk(clk), .arst_n(arst_n),
   .serial_clk(serial_clk), .serial_data(serial_data), .output_kill_pin(output_kill_pin),
   .fault_in(fault_in), .control_config(control_config), .modulation_level(modulation_level),
   .bias_level(bias_level), .equalizer_strength(equalizer_strength),
   .analog_ctl(analog_ctl), .fault_latched(fault_latched), .write_select(write_select),
   .write_strobe(write_strobe));

// [tb/twwrc_top_test.sv]
// self-checking bench for the two-wire control port
// assumes the mcu model owns the serial pins; kill and fault pins are driven here
`timescale 1ns/100ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin mismatches++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module twwrc_top_test
   import twwrc_pkg::*;
;
   logic clk, arst_n, output_kill_pin, fault_in, fault_latched, write_strobe;
   wire serial_clk, serial_data;
   twwrc_control_t control_config;
   twwrc_analog_ctl_t analog_ctl;
   logic [7:0] modulation_level, bias_level, equalizer_strength, write_select;
   logic [7:0] exp_regs [4];
   int mismatches, checks;
   twwrc_top uut (.clk(clk), .arst_n(arst_n), .serial_clk(serial_clk),
      .serial_data(serial_data), .output_kill_pin(output_kill_pin), .fault_in(fault_in),
      .control_config(control_config), .modulation_level(modulation_level),
      .bias_level(bias_level), .equalizer_strength(equalizer_strength),
      .analog_ctl(analog_ctl), .fault_latched(fault_latched),
      .write_select(write_select), .write_strobe(write_strobe));
   twwrc_mcu_model mcu (.clk(clk), .serial_clk(serial_clk), .serial_data(serial_data));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic report_and_stop();
      $display("checks=%0d mismatches=%0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // ***************
   // frame with bounded wait for the commit strobe
   // ***************
   task automatic wr(input logic [2:0] a, input logic [7:0] d, input bit stop);
      int n;
      mcu.send({a, d}, stop);
      n = 0;
      while (write_strobe !== 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
      end
      if (stop) begin
         `CHK(write_select, 8'h01 << a)
         if (n == 20) begin
            mismatches++;
            report_and_stop();
         end
         // bit 0 of the config register never holds a one
         if (a < 3'h4) exp_regs[a[1:0]] = (a == 3'h0) ? (d & 8'hfe) : d;
      end else begin
         `CHK(write_strobe, 1'b0)
      end
      repeat (2) @(negedge clk);
      `CHK({control_config, modulation_level, bias_level, equalizer_strength}, {exp_regs[0], exp_regs[1], exp_regs[2], exp_regs[3]})
   endtask
   task automatic fault_pulse();
      @(posedge clk) fault_in <= 1'b1;
      repeat (8) @(posedge clk);
      fault_in <= 1'b0;
      repeat (8) @(negedge clk);
   endtask
   task automatic t_reset();
      `CHK(analog_ctl, 19'h00100)
   endtask
   task automatic t_regs();
      wr(3'h0, 8'h87, 1'b1);
      wr(3'h1, 8'ha5, 1'b1);
      wr(3'h2, 8'h3c, 1'b1);
      wr(3'h3, 8'h5a, 1'b1);
      `CHK(analog_ctl, {1'b1, 1'b1, 8'ha5, 1'b0, 8'h5a})
      wr(3'h0, 8'h80, 1'b1);
      `CHK(analog_ctl, {1'b1, 1'b0, 8'ha5, 1'b1, 8'h5a})
   endtask
   task automatic t_reserved();
      for (int a = 4; a < 8; a++) wr(a[2:0], 8'hff, 1'b1);
   endtask
   task automatic t_nostop();
      wr(3'h1, 8'h0f, 1'b0);
      wr(3'h1, 8'h11, 1'b1);
   endtask
   task automatic t_kill();
      @(posedge clk) output_kill_pin <= 1'b1;
      repeat (8) @(negedge clk);
      `CHK(analog_ctl.modulation_enable, 1'b0)
      @(posedge clk) output_kill_pin <= 1'b0;
      repeat (8) @(negedge clk);
      `CHK(analog_ctl.modulation_enable, 1'b1)
   endtask
   task automatic t_fault();
      fault_pulse();
      `CHK(fault_latched, 1'b0)
      wr(3'h0, 8'h88, 1'b1);
      fault_pulse();
      `CHK(fault_latched, 1'b1)
      `CHK(analog_ctl.modulation_enable, 1'b0)
      wr(3'h0, 8'h08, 1'b1);
      wr(3'h0, 8'h88, 1'b1);
      `CHK(fault_latched, 1'b0)
      `CHK(analog_ctl.modulation_enable, 1'b1)
   endtask
   initial begin
      arst_n = 1'b0;
      output_kill_pin = 1'b0;
      fault_in = 1'b0;
      exp_regs = '{default: 8'h00};
      mismatches = 0;
      checks = 0;
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      repeat (4) @(negedge clk);
      t_reset();
      @(posedge clk);
      t_regs();
      t_reserved();
      t_nostop();
      t_kill();
      t_fault();
      report_and_stop();
   end
endmodule
